// File: hw/ldr_params.svh
/*
 Constants of the LED matrix dimming and refresh block: timing,
 register offsets, reset values. Assumes a 40 MHz system clock.
*/
//
// Contract
// - Three 7-bit colour gains scale sink current by value over 127.
// - Red sinks use gain one, green gain two, blue gain three, fixed.
// - Each dot has an 8-bit gain; current is peak*gain/127*dot/255.
// - Each dot has an 8-bit or 16-bit duty; 16-bit uses spread PWM.
// - Dot group code 00 none, 01..11 pick one of three duty groups.
// - Applied duty is individual times group times global duty.
// - PWM runs at 125 kHz or 62.5 kHz by a frequency select.
// - Optional phase shift turns red on first, then green, then blue.
// - Optional sink delay turns sinks on one clock after the line; the code waits 2 clocks, or 3 at 62.5 kHz.
// - Curve select picks gamma or linear, at both duty depths.
// - Each dot has an on/off bit gating it regardless of dimming.
// - Refresh mode one shows 8-bit duty at once, no frame sync.
// - Modes two and three hold duty until a frame sync arrives.
// - 16-bit duty storage sits apart from 8-bit duty storage.
// - Pixel storage takes partial updates with auto-increment.
// - Open check needs duty 25 or 6400, fault after 4 subperiods.
// - Open fault sets global and dot bits; 0Fh clears them.
// - Open blanking keeps an open dot's sink off on its line.
// - Short check needs duty 25 or 6400, fault after 4 subperiods.
// - Short fault sets global and dot bits; 0Fh clears them.
// - Short option disables upside de-ghost on a shorted line.
// - Scan lines run in order from 0 up to the configured count.
// - In frame modes peak current latches only while run is 0.
`ifndef LDR_PARAMS_SVH
`define LDR_PARAMS_SVH

`define LDR_CLK_MHZ      40
`define LDR_CYC(ps)      (((ps) * `LDR_CLK_MHZ + 999999) / 1000000)
`define LDR_WIN_FAST_PS  8000000
`define LDR_WIN_SLOW_PS  16000000
`define LDR_BLANK_PS     1000000
`define LDR_SHIFT_PS     125000
`define LDR_DLY_FAST_PS  31250
`define LDR_DLY_SLOW_PS  62500
`define LDR_SAMPLE_CYC   4
`define LDR_PERSIST      4
`define LDR_THR8         25
`define LDR_THR16        6400
`define LDR_CLEAR_KEY    8'h0F

`define LDR_A_CTRL       8'h00
`define LDR_A_PEAK       8'h04
`define LDR_A_GLOBAL     8'h08
`define LDR_A_GDUTY      8'h0C
`define LDR_A_GAIN       8'h10
`define LDR_A_FAULT      8'h14
`define LDR_A_OCLR       8'h18
`define LDR_A_SCLR       8'h1C
`define LDR_A_OBITS_LO   8'h20
`define LDR_A_OBITS_HI   8'h24
`define LDR_A_SBITS_LO   8'h28
`define LDR_A_SBITS_HI   8'h2C
`define LDR_A_ONOFF_LO   8'h30
`define LDR_A_ONOFF_HI   8'h34
`define LDR_A_PTR        8'h38
`define LDR_A_PWM8       8'h3C
`define LDR_A_PWM16      8'h40
`define LDR_A_DGAIN      8'h44
`define LDR_A_GROUP      8'h48
`define LDR_A_STATUS     8'h4C

`define LDR_CTRL_RST     12'h00C
`define LDR_PEAK_RST     3'h3
`define LDR_DUTY_RST     8'hFF
`define LDR_GAIN_RST     7'h40
`define LDR_DGAIN_RST    8'h80

`endif

// File: hw/ldr_pkg.sv
/*
 Types of the LED matrix dimming and refresh block.
 Assumes ldr_params.svh supplies the numeric constants.
*/
package ldr_pkg;
    typedef enum logic [1:0] {
        LDR_MODE_LIVE    = 2'b00,
        LDR_MODE_FRAME8  = 2'b01,
        LDR_MODE_FRAME16 = 2'b10
    } ldr_mode_t;

    typedef enum logic {
        LDR_ST_DRIVE = 1'b0,
        LDR_ST_BLANK = 1'b1
    } ldr_state_t;

    typedef struct packed {
        logic       sdeg_off;
        logic       oblank;
        logic       curve;
        logic       sdly;
        logic       phase;
        logic       freq;
        ldr_mode_t  mode;
        logic [2:0] lines;
        logic       run;
    } ldr_ctrl_t;

    typedef struct packed {
        logic        on;
        logic [14:0] level;
    } ldr_sink_t;
endpackage : ldr_pkg

// File: hw/ldr_dimming.sv
/*
 Per-dot dimming, scan and fault logic of a 7 line by 6 sink LED
 matrix, with an Avalon-MM slave for its registers.
 Assumes comparator and frame sync inputs are asynchronous pins.
*/
// Added by the designer: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "ldr_params.svh"

module ldr_dimming
    import ldr_pkg::*;
#(
    parameter int LINES = 7,
    parameter int SINKS = 6
)(
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic [7:0]        avs_address_in,
    input  wire logic              avs_read_in,
    input  wire logic              avs_write_in,
    input  wire logic [31:0]       avs_writedata_in,
    output logic [31:0]            avs_readdata_out,
    output logic                   avs_waitrequest_out,
    input  wire logic              frame_sync_in,
    input  wire logic [SINKS-1:0]  open_cmp_in,
    input  wire logic [SINKS-1:0]  short_cmp_in,
    output logic [LINES-1:0]       scan_line_out,
    output ldr_sink_t [SINKS-1:0]  sink_out,
    output logic [2:0]             peak_current_limit_out,
    output logic                   deghost_out
);
    localparam int DOTS = LINES * SINKS;
    localparam logic [9:0] WIN_F  = 10'(`LDR_CYC(`LDR_WIN_FAST_PS));
    localparam logic [9:0] WIN_S  = 10'(`LDR_CYC(`LDR_WIN_SLOW_PS));
    localparam logic [9:0] BLANK  = 10'(`LDR_CYC(`LDR_BLANK_PS));
    localparam logic [9:0] SHIFT  = 10'(`LDR_CYC(`LDR_SHIFT_PS));
    localparam logic [9:0] DLY_F  = 10'(`LDR_CYC(`LDR_DLY_FAST_PS));
    localparam logic [9:0] DLY_S  = 10'(`LDR_CYC(`LDR_DLY_SLOW_PS));
    localparam logic [9:0] SAMP   = 10'(`LDR_SAMPLE_CYC);
    localparam logic [2:0] PMAX   = 3'(`LDR_PERSIST - 1);

    ////////////////////////////////////////////////////////////////
    // Registers
    ldr_ctrl_t        ctrl;
    logic [2:0]       peak;
    logic [7:0]       glob;
    logic [7:0]       gduty [3];
    logic [6:0]       ggain [3];
    logic [5:0]       ptr;
    logic [2:0]       line_q;
    logic [DOTS-1:0]  onoff;
    logic [DOTS-1:0]  obit;
    logic [DOTS-1:0]  sbit;
    logic [7:0]       pwm8  [DOTS];
    logic [15:0]      pwm16 [DOTS];
    logic [7:0]       act8  [DOTS];
    logic [15:0]      act16 [DOTS];
    logic [7:0]       dgain [DOTS];
    logic [1:0]       grp   [DOTS];
    logic [2:0]       ocnt  [DOTS];
    logic [2:0]       scnt  [DOTS];

    logic acc;
    logic wr;
    logic live;
    logic wide;
    logic clr_o;
    logic clr_s;
    logic [31:0] wd;

    assign acc   = (avs_read_in | avs_write_in) & ~avs_waitrequest_out;
    assign wr    = acc & avs_write_in;
    assign wd    = avs_writedata_in;
    assign live  = ctrl.mode != LDR_MODE_FRAME8 &&
                   ctrl.mode != LDR_MODE_FRAME16;
    assign wide  = ctrl.mode == LDR_MODE_FRAME16;
    assign clr_o = wr && avs_address_in == `LDR_A_OCLR &&
                   wd[7:0] == `LDR_CLEAR_KEY;
    assign clr_s = wr && avs_address_in == `LDR_A_SCLR &&
                   wd[7:0] == `LDR_CLEAR_KEY;

    ////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, read data latched on the first
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            avs_waitrequest_out <= 1'b1;
        end else if (acc) begin
            avs_waitrequest_out <= 1'b1;
        end else if (avs_read_in | avs_write_in) begin
            avs_waitrequest_out <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (avs_read_in && avs_waitrequest_out) begin
            unique case (avs_address_in)
                `LDR_A_CTRL:     avs_readdata_out <= 32'(ctrl);
                `LDR_A_PEAK:     avs_readdata_out <= 32'(peak);
                `LDR_A_GLOBAL:   avs_readdata_out <= 32'(glob);
                `LDR_A_GDUTY:    avs_readdata_out <=
                    {8'h00, gduty[2], gduty[1], gduty[0]};
                `LDR_A_GAIN:     avs_readdata_out <= {9'h000, ggain[2],
                    1'b0, ggain[1], 1'b0, ggain[0]};
                `LDR_A_FAULT:    avs_readdata_out <= {30'h0, |sbit, |obit};
                `LDR_A_OBITS_LO: avs_readdata_out <= obit[31:0];
                `LDR_A_OBITS_HI: avs_readdata_out <= 32'(obit[DOTS-1:32]);
                `LDR_A_SBITS_LO: avs_readdata_out <= sbit[31:0];
                `LDR_A_SBITS_HI: avs_readdata_out <= 32'(sbit[DOTS-1:32]);
                `LDR_A_ONOFF_LO: avs_readdata_out <= onoff[31:0];
                `LDR_A_ONOFF_HI: avs_readdata_out <= 32'(onoff[DOTS-1:32]);
                `LDR_A_PTR:      avs_readdata_out <= 32'(ptr);
                `LDR_A_PWM8:     avs_readdata_out <= 32'(pwm8[ptr]);
                `LDR_A_PWM16:    avs_readdata_out <= 32'(pwm16[ptr]);
                `LDR_A_DGAIN:    avs_readdata_out <= 32'(dgain[ptr]);
                `LDR_A_GROUP:    avs_readdata_out <= 32'(grp[ptr]);
                `LDR_A_STATUS:   avs_readdata_out <= 32'(line_q);
                default:         avs_readdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // Control words
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl  <= ldr_ctrl_t'(`LDR_CTRL_RST);
            peak  <= `LDR_PEAK_RST;
            glob  <= `LDR_DUTY_RST;
            gduty <= '{default: `LDR_DUTY_RST};
            ggain <= '{default: `LDR_GAIN_RST};
            onoff <= '0;
        end else if (wr) begin
            unique case (avs_address_in)
                `LDR_A_CTRL:     ctrl <= ldr_ctrl_t'(wd[11:0]);
                `LDR_A_PEAK:     peak <= wd[2:0];
                `LDR_A_GLOBAL:   glob <= wd[7:0];
                `LDR_A_GDUTY:    gduty <= '{wd[7:0], wd[15:8], wd[23:16]};
                `LDR_A_GAIN:     ggain <= '{wd[6:0], wd[14:8], wd[22:16]};
                `LDR_A_ONOFF_LO: onoff[31:0] <= wd;
                `LDR_A_ONOFF_HI: onoff[DOTS-1:32] <= wd[DOTS-33:0];
                default: ;
            endcase
        end
    end

    // Pointer steps on every data port access, read or write
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ptr <= 6'h00;
        end else if (wr && avs_address_in == `LDR_A_PTR) begin
            ptr <= (wd[5:0] < 6'(DOTS)) ? wd[5:0] : 6'h00;
        end else if (acc && avs_address_in >= `LDR_A_PWM8 &&
                     avs_address_in <= `LDR_A_GROUP) begin
            ptr <= (ptr == 6'(DOTS - 1)) ? 6'h00 : ptr + 6'h01;
        end
    end

    // Pixel storage; 8-bit and 16-bit duty at separate ports
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pwm8  <= '{default: 8'h00};
            pwm16 <= '{default: 16'h0000};
            dgain <= '{default: `LDR_DGAIN_RST};
            grp   <= '{default: 2'h0};
        end else if (wr) begin
            unique case (avs_address_in)
                `LDR_A_PWM8:  pwm8[ptr]  <= wd[7:0];
                `LDR_A_PWM16: pwm16[ptr] <= wd[15:0];
                `LDR_A_DGAIN: dgain[ptr] <= wd[7:0];
                `LDR_A_GROUP: grp[ptr]   <= wd[1:0];
                default: ;
            endcase
        end
    end

    // Peak current follows at once in mode one, else only while stopped
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            peak_current_limit_out <= `LDR_PEAK_RST;
        end else if (live || !ctrl.run) begin
            peak_current_limit_out <= peak;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic fs1;
    logic fs2;
    logic fs3;
    logic fs_edge;
    logic [SINKS-1:0] oc1;
    logic [SINKS-1:0] oc2;
    logic [SINKS-1:0] sc1;
    logic [SINKS-1:0] sc2;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            {fs1, fs2, fs3} <= 3'h0;
            {oc1, oc2, sc1, sc2} <= '0;
        end else begin
            {fs3, fs2, fs1} <= {fs2, fs1, frame_sync_in};
            {oc2, oc1} <= {oc1, open_cmp_in};
            {sc2, sc1} <= {sc1, short_cmp_in};
        end
    end

    // Only the rising edge counts, so a long sync pulse loads once
    assign fs_edge = fs2 & ~fs3;

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            act8  <= '{default: 8'h00};
            act16 <= '{default: 16'h0000};
        end else if (!live && fs_edge) begin
            act8  <= pwm8;
            act16 <= pwm16;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Line sequencer
    ldr_state_t  state;
    logic [10:0] tcnt;
    logic [2:0]  last;
    logic [7:0]  sub_q;
    logic [9:0]  win;
    logic [9:0]  shift;
    logic [9:0]  dly;
    logic [10:0] drive_len;

    assign win       = ctrl.freq ? WIN_S : WIN_F;
    assign shift     = ctrl.phase ? SHIFT : 10'h000;
    assign dly       = !ctrl.sdly ? 10'h000 :
                       ctrl.freq ? DLY_S : DLY_F;
    assign drive_len = 11'(win) + 11'(shift) + 11'(shift);
    assign last      = (ctrl.lines > 3'(LINES - 1)) ?
                       3'(LINES - 1) : ctrl.lines;

    always_ff @(posedge clk_in) begin
        if (rst_in || !ctrl.run) begin
            state  <= LDR_ST_DRIVE;
            tcnt   <= 11'h000;
            line_q <= 3'h0;
        end else begin
            unique case (state)
                LDR_ST_DRIVE: begin
                    if (tcnt == drive_len - 11'h001) begin
                        state <= LDR_ST_BLANK;
                        tcnt  <= 11'h000;
                    end else begin
                        tcnt <= tcnt + 11'h001;
                    end
                end
                LDR_ST_BLANK: begin
                    if (tcnt == 11'(BLANK) - 11'h001) begin
                        state  <= LDR_ST_DRIVE;
                        tcnt   <= 11'h000;
                        line_q <= (line_q >= last) ? 3'h0 :
                                  line_q + 3'h1;
                    end else begin
                        tcnt <= tcnt + 11'h001;
                    end
                end
            endcase
        end
    end

    // Subperiod count feeds the spread-duty dither
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sub_q <= 8'h00;
        end else if (state == LDR_ST_BLANK && line_q >= last &&
                     tcnt == 11'(BLANK) - 11'h001) begin
            sub_q <= sub_q + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Per-sink duty, gain and fault sampling
    logic [SINKS-1:0] next_on;
    logic [SINKS-1:0] samp;
    logic [5:0]       dot_i [SINKS];
    logic [14:0]      lvl   [SINKS];
    logic [7:0]       dith;

    // Bit reversal spreads the leftover fraction evenly over subperiods
    assign dith = wide ? 8'({<<{sub_q}}) : 8'h00;

    for (genvar s = 0; s < SINKS; s++) begin : g_sink
        localparam int COL = s % 3;
        logic [7:0]  d8;
        logic [15:0] ind;
        logic [31:0] sq;
        logic [15:0] crv;
        logic [1:0]  g;
        logic [8:0]  gd;
        logic [33:0] prod;
        logic [25:0] sc;
        logic [9:0]  on_c;
        logic [9:0]  st;
        logic        elig;
        logic        gate;

        always_comb begin
            dot_i[s] = 6'(int'(line_q) * SINKS + s);
            d8   = live ? pwm8[dot_i[s]] : act8[dot_i[s]];
            ind  = wide ? act16[dot_i[s]] : {d8, d8};
            sq   = 32'(ind) * 32'(ind);
            crv  = ctrl.curve ? sq[31:16] : ind;
            g    = grp[dot_i[s]];
            gd   = (g == 2'h0) ? 9'h100 :
                   {1'b0, gduty[2'(g - 2'h1)]} + 9'h001;
            prod = 34'(crv) * 34'(gd) * 34'({1'b0, glob} + 9'h001);
            sc   = 26'(prod[33:16]) * 26'(win) + 26'({dith, 8'h00});
            on_c = sc[25:16];
            st   = 10'(COL) * shift + dly;
            elig = wide ? (ind >= 16'(`LDR_THR16)) :
                          (d8 >= 8'(`LDR_THR8));
            gate = ctrl.run && state == LDR_ST_DRIVE &&
                   onoff[dot_i[s]] &&
                   !(ctrl.oblank && obit[dot_i[s]]);
            next_on[s] = gate && tcnt >= 11'(st) &&
                         tcnt < 11'(st) + 11'(on_c);
            samp[s] = gate && elig && on_c > SAMP &&
                      tcnt == 11'(st) + 11'(SAMP);
            lvl[s] = 15'(ggain[COL]) * 15'(dgain[dot_i[s]]);
        end
    end

    // Fault persistence; a new fault wins over a clear in the same cycle
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            obit <= '0;
            sbit <= '0;
            ocnt <= '{default: 3'h0};
            scnt <= '{default: 3'h0};
        end else begin
            if (clr_o) obit <= '0;
            if (clr_s) sbit <= '0;
            for (int s = 0; s < SINKS; s++) begin
                if (samp[s]) begin
                    if (!oc2[s]) begin
                        ocnt[dot_i[s]] <= 3'h0;
                    end else if (ocnt[dot_i[s]] >= PMAX) begin
                        obit[dot_i[s]] <= 1'b1;
                    end else begin
                        ocnt[dot_i[s]] <= ocnt[dot_i[s]] + 3'h1;
                    end
                    if (!sc2[s]) begin
                        scnt[dot_i[s]] <= 3'h0;
                    end else if (scnt[dot_i[s]] >= PMAX) begin
                        sbit[dot_i[s]] <= 1'b1;
                    end else begin
                        scnt[dot_i[s]] <= scnt[dot_i[s]] + 3'h1;
                    end
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Output stage
    logic line_short;
    assign line_short = |sbit[6'(int'(line_q) * SINKS) +: SINKS];

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            scan_line_out <= '0;
            sink_out      <= '0;
            deghost_out   <= 1'b0;
        end else begin
            scan_line_out <= (ctrl.run && state == LDR_ST_DRIVE) ?
                LINES'(1) << line_q : '0;
            for (int s = 0; s < SINKS; s++) begin
                sink_out[s].on    <= next_on[s];
                sink_out[s].level <= lvl[s];
            end
            deghost_out <= ctrl.run && state == LDR_ST_BLANK &&
                           !(ctrl.sdeg_off && line_short);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    AST_BUS_ONE_WAIT: assert property (
        (avs_read_in | avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("bus answer not one cycle");
    AST_SCAN_ONEHOT: assert property (
        $onehot0(scan_line_out))
        else $error("scan lines not one-hot");
    AST_SINK_IN_LINE: assert property (
        sink_out[0].on |-> |scan_line_out)
        else $error("sink on with no scan line");
    AST_LINE_ORDER: assert property (
        $changed(line_q) && line_q != 3'h0 |-> line_q == $past(line_q) + 3'h1)
        else $error("scan line skipped");
    AST_FRAME_HOLD: assert property (
        !live && !fs_edge |=> act8[0] == $past(act8[0]))
        else $error("frame data changed without sync");
    AST_DOT_OFF: assert property (
        !onoff[dot_i[0]] |=> !sink_out[0].on)
        else $error("dot on while switched off");
    AST_OPEN_BLANK: assert property (
        ctrl.oblank && obit[dot_i[0]] |=> !sink_out[0].on)
        else $error("open dot not blanked");
    AST_OPEN_CLEAR: assert property (
        clr_o && samp == '0 |=> obit == '0)
        else $error("open bits not cleared");
    AST_PEAK_HOLD: assert property (
        !live && ctrl.run |=> $stable(peak_current_limit_out))
        else $error("peak changed while running");
    AST_SHORT_DEGHOST: assert property (
        ctrl.sdeg_off && line_short && $stable(line_q) |=> !deghost_out)
        else $error("de-ghost on shorted line");

    COV_FRAME_LOAD: cover property (!live && fs_edge);
    COV_OPEN_FAULT: cover property ($rose(|obit));
    COV_LINE_WRAP: cover property ($fell(line_q != 3'h0));
endmodule : ldr_dimming

// File: bench/ldr_led_model.sv
/* LED matrix stand-in: fault masks become comparator levels.
 Assumes the six-sink packing of ldr_sink_t. */
`timescale 1ns/1ps
module ldr_led_model
    import ldr_pkg::*;
(
    input  wire ldr_sink_t [5:0] sink_in,
    input  wire logic [5:0]      open_in,
    input  wire logic [5:0]      short_in,
    output logic [5:0]           open_cmp_out,
    output logic [5:0]           short_cmp_out
);
    // A dark sink shows no fault, so faults only appear while driven
    always_comb begin
        for (int s = 0; s < 6; s++) begin
            open_cmp_out[s]  = sink_in[s].on & open_in[s];
            short_cmp_out[s] = sink_in[s].on & short_in[s];
        end
    end
endmodule : ldr_led_model

// File: bench/tb.sv
/* Self-checking bench of the dimming block.
 Assumes the reset register map and a 25 ns clock. */
`timescale 1ns/1ps
`include "ldr_params.svh"
module tb
    import ldr_pkg::*;
;
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
    logic            clk_in, rst_in, rd, wr, fs, dg;
    logic [7:0]      adr;
    logic [31:0]     wd, rdat;
    logic            waitreq;
    logic [5:0]      ocmp, scmp, om, sm;
    logic [6:0]      scan;
    logic [2:0]      peak;
    ldr_sink_t [5:0] sink;
    int              err_total, checked;
    ldr_dimming u_ldr_dimming (.clk_in(clk_in), .rst_in(rst_in),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wd), .avs_readdata_out(rdat),
        .avs_waitrequest_out(waitreq), .frame_sync_in(fs),
        .open_cmp_in(ocmp), .short_cmp_in(scmp), .scan_line_out(scan),
        .sink_out(sink), .peak_current_limit_out(peak), .deghost_out(dg));
    ldr_led_model u_ldr_led_model (.sink_in(sink), .open_in(om),
        .short_in(sm), .open_cmp_out(ocmp), .short_cmp_out(scmp));
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_in);
        adr <= a;
        wr  <= w;
        rd  <= !w;
        wd  <= d;
        @(posedge clk_in);
        while (waitreq !== 1'b0) begin
            @(posedge clk_in);
        end
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus
    task automatic put(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : put
    task automatic get(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        `CHK(q, e)
    endtask : get
    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        get(`LDR_A_CTRL, 32'h0000000C);
        get(`LDR_A_PEAK, 32'h00000003);
        get(`LDR_A_GAIN, 32'h00404040);
        get(`LDR_A_GDUTY, 32'h00FFFFFF);
        get(`LDR_A_GLOBAL, 32'h000000FF);
        get(8'h50, 32'h00000000);
        put(`LDR_A_FAULT, 32'h00000003);
        get(`LDR_A_FAULT, 32'h00000000);
        `CHK(peak, 3'h3)
        $display("test reset done");
    endtask : t_reset
    task automatic t_ptr();
        put(`LDR_A_PTR, 32'h0);
        put(`LDR_A_DGAIN, 32'h11);
        put(`LDR_A_DGAIN, 32'h22);
        put(`LDR_A_PTR, 32'h0);
        get(`LDR_A_DGAIN, 32'h00000011);
        get(`LDR_A_DGAIN, 32'h00000022);
        $display("test pointer done");
    endtask : t_ptr
    task automatic t_scan();
        int n;
        put(`LDR_A_ONOFF_LO, 32'h1);
        put(`LDR_A_PTR, 32'h0);
        put(`LDR_A_PWM8, 32'hFF);
        put(`LDR_A_CTRL, 32'h0000000D);
        n = 0;
        while (scan !== 7'h01 && n < 40) begin
            @(posedge clk_in);
            n++;
        end
        repeat (3) @(posedge clk_in);
        `CHK(scan, 7'h01)
        `CHK(sink[0].level, 15'h0440)
        `CHK(sink[0].on, 1'b1)
        `CHK(sink[3].on, 1'b0)
        $display("test scan done");
    endtask : t_scan
    // Lands a few cycles into a fresh drive of line 0
    task automatic line0();
        while (scan !== 7'h40) @(posedge clk_in);
        while (scan !== 7'h01) @(posedge clk_in);
        repeat (3) @(posedge clk_in);
    endtask : line0
    task automatic t_open();
        om <= 6'h01;
        sm <= 6'h01;
        // Seven lines of 360 cycles make one subperiod
        repeat (5 * 2520 + 50) @(posedge clk_in);
        om <= 6'h00;
        sm <= 6'h00;
        get(`LDR_A_FAULT, 32'h00000003);
        get(`LDR_A_OBITS_LO, 32'h00000001);
        get(`LDR_A_SBITS_LO, 32'h00000001);
        put(`LDR_A_CTRL, 32'h00000C0D);
        line0();
        `CHK(sink[0].on, 1'b0)
        while (scan !== 7'h00) @(posedge clk_in);
        `CHK(dg, 1'b0)
        while (scan !== 7'h02) @(posedge clk_in);
        while (scan !== 7'h00) @(posedge clk_in);
        `CHK(dg, 1'b1)
        put(`LDR_A_OCLR, 32'h05);
        get(`LDR_A_OBITS_LO, 32'h00000001);
        put(`LDR_A_OCLR, 32'h0F);
        get(`LDR_A_FAULT, 32'h00000002);
        put(`LDR_A_SCLR, 32'h0F);
        get(`LDR_A_FAULT, 32'h00000000);
        $display("test open done");
    endtask : t_open
    task automatic t_frame();
        put(`LDR_A_CTRL, 32'h0000001D);
        put(`LDR_A_PEAK, 32'h00000005);
        repeat (2) @(posedge clk_in);
        `CHK(peak, 3'h3)
        put(`LDR_A_PTR, 32'h0);
        put(`LDR_A_PWM8, 32'h80);
        line0();
        `CHK(sink[0].on, 1'b0)
        fs <= 1'b1;
        repeat (4) @(posedge clk_in);
        fs <= 1'b0;
        line0();
        `CHK(sink[0].on, 1'b1)
        put(`LDR_A_CTRL, 32'h0000001C);
        repeat (2) @(posedge clk_in);
        `CHK(peak, 3'h5)
        `CHK(scan, 7'h00)
        $display("test frame done");
    endtask : t_frame
    ////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #(25 * 60000);
        err_total++;
        report_and_stop();
    end
    initial begin
        {rd, wr, fs, om, sm, adr, wd} = '0;
        err_total = 0;
        checked = 0;
        rst_in = 1'b1;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_ptr();
        t_scan();
        t_open();
        t_frame();
        report_and_stop();
    end
endmodule : tb
